// >>> common/poc_if.sv
// Carrier between the configuration top and the offset holder
`timescale 1ns/1ps
interface poc_if;
   logic host_wr_mag;
   logic host_wr_sign;
   logic [7:0] host_wdata;
   logic cal_load;
   logic [7:0] cal_mag;
   logic cal_sign;
   logic dec_req;
   logic [7:0] mag;
   logic sign;
   modport ctrl
   (
      output host_wr_mag, host_wr_sign, host_wdata, cal_load, cal_mag, cal_sign, dec_req,
      input mag, sign
   );
   modport adj
   (
      input host_wr_mag, host_wr_sign, host_wdata, cal_load, cal_mag, cal_sign, dec_req,
      output mag, sign
   );
endinterface : poc_if

// >>> common/poc_pkg.sv
// Constants for the proximity offset calibration configuration block
package poc_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_OFFSET_MAG = 8'hC0;
   localparam logic [7:0] ADDR_OFFSET_SIGN = 8'hC1;
   localparam logic [7:0] ADDR_RANGE_EXT_CTRL = 8'hD8;
   localparam logic [7:0] ADDR_CAL_CFG = 8'hD9;
   localparam logic [7:0] ADDR_CAL_STAT = 8'hDC;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_RANGE_EXT_CTRL = 8'h00;
   localparam logic [7:0] RST_CAL_CFG = 8'h50;
   localparam logic [7:0] RST_OFFSET_MAG = 8'h00;
   localparam logic RST_OFFSET_SIGN = 1'b0;
   // ==========================================================
   // Field positions
   localparam int RX_RSVD_BIT = 7;
   localparam int RX_AUTO_BIT = 6;
   localparam int RX_EN_BIT = 5;
   localparam int RX_STEPS_HI = 4;
   localparam int CC_TARGET_HI = 7;
   localparam int CC_TARGET_LO = 5;
   localparam int CC_RSVD_BIT = 4;
   localparam int CC_DEC_EN_BIT = 3;
   localparam int CC_AVG_HI = 2;
   localparam int CS_DEC_FLAG_BIT = 2;
   // ==========================================================
   // Second stage gain codes
   typedef enum logic [1:0]
   {
      POC_GAIN_2P5X = 2'b00,
      POC_GAIN_5X = 2'b01,
      POC_GAIN_10X = 2'b10,
      POC_GAIN_10X_ALT = 2'b11
   } poc_gain_t;
   // Calibration target base: target = (TARGET_BASE << code) - 1
   localparam logic [9:0] TARGET_BASE = 10'h004;
endpackage : poc_pkg

// >>> hdl/poc_cal_config.sv
// Proximity offset calibration configuration and auto offset adjust
// Operation
// - Auto range bit set: device loads computed step count at calibration end.
// - Range extension applied only while enable bit is one; else nominal.
// - Five-bit step field gives nominal plus value steps, zero to 31.
// - Gain 2.5x uses all bits; 5x drops bit 0; 10x drops two.
// - Calibration end leaves offset magnitude and sign readable in offset registers.
// - Auto adjust on and proximity running: zero ADC result decrements offset.
// - Each automatic decrement sets a sticky offset-decremented flag.
// - No automatic decrement for a disabled photodiode.
// - Flag clears on host writing one, or auto adjust bit cleared.
`timescale 1ns/1ps
module poc_cal_config
   import poc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] second_stage_gain,
   input wire logic prox_running,
   input wire logic pd_enable,
   input wire logic adc_valid,
   input wire logic adc_zero,
   input wire logic cal_done,
   input wire logic [4:0] cal_range_steps,
   input wire logic [7:0] cal_offset_mag,
   input wire logic cal_offset_sign,
   output logic [4:0] range_ext_out,
   output logic [9:0] cal_target_value,
   output logic auto_range_calc_en,
   output logic zero_result_decrement_en,
   output logic offset_decremented_flag,
   output logic [7:0] offset_magnitude,
   output logic offset_sign
);
   // ==========================================================
   // Decode helpers
   function automatic logic [4:0] mask_steps(input logic [4:0] steps, input logic [1:0] gain);
      logic [4:0] m;
      m = steps;
      if (gain == POC_GAIN_5X)
         m[0] = 1'b0;
      else if (gain != POC_GAIN_2P5X)
         m[1:0] = 2'b00;
      return m;
   endfunction : mask_steps

   function automatic logic [9:0] target_of(input logic [2:0] code);
      return (TARGET_BASE << code) - 10'h001;
   endfunction : target_of

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] want);
      return addr == want;
   endfunction : hit

   // ==========================================================
   // Register state
   logic [7:0] range_ctrl;
   logic [7:0] cal_cfg;
   logic [7:0] next_range_ctrl;
   logic [7:0] next_cal_cfg;
   logic next_flag;
   logic [7:0] next_rdata;
   logic [4:0] next_range_ext_out;
   logic [9:0] next_target;
   logic wr_range;
   logic wr_cfg;
   logic wr_stat;
   logic dec_req;

   poc_if ofs ();

   poc_offset_adj u_adj
   (
      .clk(clk),
      .rst(rst),
      .ofs(ofs.adj)
   );

   assign wr_range = reg_wr && hit(reg_addr, ADDR_RANGE_EXT_CTRL);
   assign wr_cfg = reg_wr && hit(reg_addr, ADDR_CAL_CFG);
   assign wr_stat = reg_wr && hit(reg_addr, ADDR_CAL_STAT);

   // ==========================================================
   // Zero-result decrement request
   always_comb
   begin
      dec_req = cal_cfg[CC_DEC_EN_BIT] && prox_running && pd_enable && adc_valid && adc_zero;
   end

   assign ofs.host_wr_mag = reg_wr && hit(reg_addr, ADDR_OFFSET_MAG);
   assign ofs.host_wr_sign = reg_wr && hit(reg_addr, ADDR_OFFSET_SIGN);
   assign ofs.host_wdata = reg_wdata;
   assign ofs.cal_load = cal_done;
   assign ofs.cal_mag = cal_offset_mag;
   assign ofs.cal_sign = cal_offset_sign;
   assign ofs.dec_req = dec_req;

   // ==========================================================
   // Configuration registers
   always_comb
   begin
      next_range_ctrl = range_ctrl;
      next_cal_cfg = cal_cfg;
      if (wr_range)
         next_range_ctrl = reg_wdata;
      else if (cal_done && range_ctrl[RX_AUTO_BIT])
      begin
         next_range_ctrl[RX_STEPS_HI:0] = cal_range_steps;
      end
      if (wr_cfg)
         next_cal_cfg = reg_wdata;
   end

   // ==========================================================
   // Sticky offset-decremented flag, set wins over clear
   always_comb
   begin
      next_flag = offset_decremented_flag;
      if ((wr_stat && reg_wdata[CS_DEC_FLAG_BIT]) || (wr_cfg && !reg_wdata[CC_DEC_EN_BIT]))
         next_flag = 1'b0;
      if (dec_req)
         next_flag = 1'b1;
   end

   // ==========================================================
   // Derived outputs
   always_comb
   begin
      if (range_ctrl[RX_EN_BIT])
         next_range_ext_out = mask_steps(range_ctrl[RX_STEPS_HI:0], second_stage_gain);
      else
         next_range_ext_out = 5'h00;
      next_target = target_of(cal_cfg[CC_TARGET_HI:CC_TARGET_LO]);
   end

   // ==========================================================
   // Read data
   always_comb
   begin
      next_rdata = reg_rdata;
      if (reg_rd)
      begin
         if (hit(reg_addr, ADDR_OFFSET_MAG))
            next_rdata = ofs.mag;
         else if (hit(reg_addr, ADDR_OFFSET_SIGN))
            next_rdata = {7'h00, ofs.sign};
         else if (hit(reg_addr, ADDR_RANGE_EXT_CTRL))
            next_rdata = range_ctrl;
         else if (hit(reg_addr, ADDR_CAL_CFG))
            next_rdata = cal_cfg;
         else if (hit(reg_addr, ADDR_CAL_STAT))
            next_rdata = {5'h00, offset_decremented_flag, 2'b00};
         else
            next_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         range_ctrl <= RST_RANGE_EXT_CTRL;
         cal_cfg <= RST_CAL_CFG;
         offset_decremented_flag <= 1'b0;
         reg_rdata <= 8'h00;
         range_ext_out <= 5'h00;
         cal_target_value <= 10'h000;
      end
      else
      begin
         range_ctrl <= next_range_ctrl;
         cal_cfg <= next_cal_cfg;
         offset_decremented_flag <= next_flag;
         reg_rdata <= next_rdata;
         range_ext_out <= next_range_ext_out;
         cal_target_value <= next_target;
      end
   end

   assign auto_range_calc_en = range_ctrl[RX_AUTO_BIT];
   assign zero_result_decrement_en = cal_cfg[CC_DEC_EN_BIT];
   assign offset_magnitude = ofs.mag;
   assign offset_sign = ofs.sign;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ext_disabled_a: assert property (!range_ctrl[RX_EN_BIT] |=> range_ext_out == 5'h00) else $error("extension active while off");
   ext_full_a: assert property (range_ctrl[RX_EN_BIT] && second_stage_gain == POC_GAIN_2P5X |=> range_ext_out == $past(range_ctrl[RX_STEPS_HI:0])) else $error("steps not passed");
   gain_mask_a: assert property (range_ctrl[RX_EN_BIT] && second_stage_gain != POC_GAIN_2P5X |=> range_ext_out[0] == 1'b0) else $error("low bit not ignored");
   gain_ten_a: assert property (range_ctrl[RX_EN_BIT] && second_stage_gain[1] |=> range_ext_out[1:0] == 2'b00) else $error("two low bits not ignored");
   auto_load_a: assert property (cal_done && range_ctrl[RX_AUTO_BIT] && !wr_range |=> range_ctrl[RX_STEPS_HI:0] == $past(cal_range_steps)) else $error("auto steps not loaded");
   manual_hold_a: assert property (!range_ctrl[RX_AUTO_BIT] && !wr_range |=> $stable(range_ctrl)) else $error("manual steps altered");
   target_map_a: assert property (!rst |=> cal_target_value == target_of($past(cal_cfg[CC_TARGET_HI:CC_TARGET_LO]))) else $error("wrong target");
   flag_set_a: assert property (dec_req |=> offset_decremented_flag ##1 (offset_decremented_flag || $past(wr_stat || wr_cfg))) else $error("flag not set");
   flag_clear_a: assert property (wr_stat && reg_wdata[CS_DEC_FLAG_BIT] && !dec_req |=> !offset_decremented_flag) else $error("flag not cleared");
   diode_off_a: assert property (!pd_enable && !offset_decremented_flag && !cal_done && !ofs.host_wr_mag |=> !offset_decremented_flag && $stable(ofs.mag)) else $error("decrement on disabled diode");

   dec_seen_c: cover property (dec_req ##1 offset_decremented_flag);
   auto_cal_c: cover property (cal_done && range_ctrl[RX_AUTO_BIT]);
   gain_ten_c: cover property (range_ctrl[RX_EN_BIT] && second_stage_gain == POC_GAIN_10X);
   clear_race_c: cover property (dec_req && wr_stat && reg_wdata[CS_DEC_FLAG_BIT]);
endmodule : poc_cal_config

// >>> hdl/poc_offset_adj.sv
// Offset magnitude and sign holder with saturating decrement
`timescale 1ns/1ps
module poc_offset_adj
   import poc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   poc_if.adj ofs
);
   logic [7:0] mag;
   logic sign;
   logic [7:0] next_mag;
   logic next_sign;

   // ==========================================================
   // Next value: calibration load, then host write, then decrement
   always_comb
   begin
      next_mag = mag;
      next_sign = sign;
      if (ofs.cal_load)
      begin
         next_mag = ofs.cal_mag;
         next_sign = ofs.cal_sign;
      end
      else if (ofs.host_wr_mag || ofs.host_wr_sign)
      begin
         if (ofs.host_wr_mag)
            next_mag = ofs.host_wdata;
         if (ofs.host_wr_sign)
            next_sign = ofs.host_wdata[0];
      end
      else if (ofs.dec_req)
      begin
         if (mag != 8'h00)
            next_mag = mag - 8'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mag <= RST_OFFSET_MAG;
         sign <= RST_OFFSET_SIGN;
      end
      else
      begin
         mag <= next_mag;
         sign <= next_sign;
      end
   end

   assign ofs.mag = mag;
   assign ofs.sign = sign;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic quiet;
   assign quiet = !ofs.cal_load && !ofs.host_wr_mag && !ofs.host_wr_sign;
   ofs_decrement_a: assert property (quiet && ofs.dec_req && mag != 8'h00 |=> mag == $past(mag) - 8'h01) else $error("offset not decremented");
   ofs_saturate_a: assert property (quiet && ofs.dec_req && mag == 8'h00 |=> mag == 8'h00 && $stable(sign)) else $error("offset wrapped");
   cal_result_a: assert property (ofs.cal_load |=> mag == $past(ofs.cal_mag) && sign == $past(ofs.cal_sign)) else $error("calibration result lost");
endmodule : poc_offset_adj

// >>> testbench/poc_host.sv
// Host model issuing single-byte register cycles
`timescale 1ns/1ps
module poc_host
   import poc_pkg::*;
(
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // ==========================================================
   // Write cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == ADDR_RANGE_EXT_CTRL)
         v[RX_RSVD_BIT] = 1'b0;
      if (a == ADDR_CAL_CFG)
         v[CC_RSVD_BIT] = 1'b1;
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
      #1;
   endtask : wr
   // ==========================================================
   // Read cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
endmodule : poc_host

// >>> testbench/tb_top.sv
// Self-checking bench for the offset calibration configuration block
`timescale 1ns/1ps
module tb_top
   import poc_pkg::*;
;
   logic clk, rst, reg_wr, reg_rd, prox_running, pd_enable, adc_valid, adc_zero, cal_done;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, cal_offset_mag, offset_magnitude, rv;
   logic [1:0] second_stage_gain;
   logic [4:0] cal_range_steps, range_ext_out;
   logic [9:0] cal_target_value;
   logic cal_offset_sign, auto_range_calc_en, zero_result_decrement_en;
   logic offset_decremented_flag, offset_sign;
   int err_count = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [7:0] t_d8 [7] = '{8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h1F, 8'h25, 8'h20};
   logic [1:0] t_gain [7] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b00, 2'b00, 2'b00};
   logic [4:0] t_exp [7] = '{5'h1F, 5'h1E, 5'h1C, 5'h1C, 5'h00, 5'h05, 5'h00};
   logic [9:0] t_tgt [8] = '{10'h003, 10'h007, 10'h00F, 10'h01F, 10'h03F, 10'h07F, 10'h0FF,
      10'h1FF};
   logic [7:0] r_addr [6] = '{ADDR_RANGE_EXT_CTRL, ADDR_CAL_CFG, ADDR_OFFSET_MAG, ADDR_OFFSET_SIGN,
      ADDR_CAL_STAT, 8'h10};
   logic [7:0] r_exp [6] = '{8'h00, 8'h50, 8'h00, 8'h00, 8'h00, 8'h00};
   poc_cal_config uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .second_stage_gain(second_stage_gain), .prox_running(prox_running),
      .pd_enable(pd_enable), .adc_valid(adc_valid), .adc_zero(adc_zero),
      .cal_done(cal_done), .cal_range_steps(cal_range_steps),
      .cal_offset_mag(cal_offset_mag), .cal_offset_sign(cal_offset_sign),
      .range_ext_out(range_ext_out), .cal_target_value(cal_target_value),
      .auto_range_calc_en(auto_range_calc_en),
      .zero_result_decrement_en(zero_result_decrement_en),
      .offset_decremented_flag(offset_decremented_flag),
      .offset_magnitude(offset_magnitude), .offset_sign(offset_sign));
   poc_host h (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   // ==========================================================
   // Helpers
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic settle();
      @(posedge clk);
      #1;
   endtask : settle
   task automatic adc();
      @(posedge clk);
      adc_valid <= 1'b1;
      adc_zero <= 1'b1;
      @(posedge clk);
      adc_valid <= 1'b0;
      adc_zero <= 1'b0;
      #1;
   endtask : adc
   task automatic cal_end(input logic [4:0] s, input logic [7:0] m, input logic sg);
      @(posedge clk);
      cal_done <= 1'b1;
      cal_range_steps <= s;
      cal_offset_mag <= m;
      cal_offset_sign <= sg;
      @(posedge clk);
      cal_done <= 1'b0;
      cal_range_steps <= ~s;
      cal_offset_mag <= ~m;
      cal_offset_sign <= ~sg;
      #1;
   endtask : cal_end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   // ==========================================================
   // Clock and timeout
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         err_count++;
         end_of_test();
      end
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      rst = 1'b1;
      second_stage_gain = 2'b00;
      prox_running = 1'b0;
      pd_enable = 1'b0;
      adc_valid = 1'b0;
      adc_zero = 1'b0;
      cal_done = 1'b0;
      cal_range_steps = 5'h00;
      cal_offset_mag = 8'h00;
      cal_offset_sign = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      settle();
      chk(cal_target_value, 10'h00F);
      for (int i = 0; i < 6; i++)
      begin
         h.rd(r_addr[i], rv);
         chk({2'b00, rv}, {2'b00, r_exp[i]});
      end
      $display("test reset done");
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clk);
         second_stage_gain <= t_gain[i];
         h.wr(ADDR_RANGE_EXT_CTRL, t_d8[i]);
         settle();
         chk({5'h00, range_ext_out}, {5'h00, t_exp[i]});
      end
      for (int c = 0; c < 8; c++)
      begin
         h.wr(ADDR_CAL_CFG, {c[2:0], 5'h10});
         settle();
         chk(cal_target_value, t_tgt[c]);
      end
      $display("test table done");
      h.wr(ADDR_RANGE_EXT_CTRL, 8'h60);
      cal_end(5'h13, 8'h02, 1'b1);
      chk({2'b00, offset_magnitude}, 10'h002);
      chk({9'h000, offset_sign}, 10'h001);
      chk({9'h000, auto_range_calc_en}, 10'h001);
      settle();
      chk({5'h00, range_ext_out}, 10'h013);
      h.rd(ADDR_RANGE_EXT_CTRL, rv);
      chk({2'b00, rv}, 10'h073);
      h.rd(ADDR_OFFSET_SIGN, rv);
      chk({2'b00, rv}, 10'h001);
      h.wr(ADDR_RANGE_EXT_CTRL, 8'h20);
      cal_end(5'h07, 8'h02, 1'b1);
      settle();
      h.rd(ADDR_RANGE_EXT_CTRL, rv);
      chk({2'b00, rv}, 10'h020);
      chk({5'h00, range_ext_out}, 10'h000);
      $display("test calibration done");
      h.wr(ADDR_CAL_CFG, 8'h58);
      @(posedge clk);
      prox_running <= 1'b1;
      adc();
      chk({1'b0, offset_decremented_flag, offset_magnitude}, 10'h002);
      @(posedge clk);
      prox_running <= 1'b0;
      pd_enable <= 1'b1;
      adc();
      chk({1'b0, offset_decremented_flag, offset_magnitude}, 10'h002);
      @(posedge clk);
      prox_running <= 1'b1;
      adc();
      chk({1'b0, offset_decremented_flag, offset_magnitude}, 10'h101);
      adc();
      adc();
      chk({1'b0, offset_decremented_flag, offset_magnitude}, 10'h100);
      h.rd(ADDR_CAL_STAT, rv);
      chk({2'b00, rv}, 10'h004);
      h.wr(ADDR_CAL_STAT, 8'h04);
      settle();
      chk({9'h000, offset_decremented_flag}, 10'h000);
      adc();
      chk({9'h000, offset_decremented_flag}, 10'h001);
      h.wr(ADDR_CAL_CFG, 8'h50);
      settle();
      chk({8'h00, zero_result_decrement_en, offset_decremented_flag}, 10'h000);
      $display("test decrement done");
      h.wr(ADDR_OFFSET_MAG, 8'hA5);
      h.wr(ADDR_OFFSET_SIGN, 8'h01);
      h.wr(8'h10, 8'hFF);
      h.rd(ADDR_OFFSET_MAG, rv);
      chk({2'b00, rv}, 10'h0A5);
      h.rd(ADDR_OFFSET_SIGN, rv);
      chk({2'b00, rv}, 10'h001);
      h.wr(ADDR_CAL_CFG, 8'hF8);
      settle();
      chk(cal_target_value, 10'h1FF);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      settle();
      chk(cal_target_value, 10'h00F);
      chk({offset_decremented_flag, zero_result_decrement_en, offset_magnitude}, 10'h000);
      h.rd(ADDR_RANGE_EXT_CTRL, rv);
      chk({2'b00, rv}, 10'h000);
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule : tb_top
